// ==== inc/trace_trigger_pkg.sv ====
// trace trigger package: modes, register offsets, field layout, reset values
// assumes a plain strobe register port with 8-bit byte addressing
package trace_trigger_pkg;

  // trigger modes
  typedef enum logic [2:0] {
    free_run_mode        = 3'b000,
    marked_address_mode  = 3'b001,
    no_capture_mode      = 3'b010,
    start_stop_window    = 3'b011,
    capture_after_match  = 3'b100,
    capture_before_match = 3'b101
  } trig_mode_e;

  // window states
  typedef enum logic [1:0] {
    win_idle    = 2'b00,
    win_active  = 2'b01,
    win_done    = 2'b10
  } win_state_e;

  localparam int ADDR_W  = 15;
  localparam int PTR_W   = 12;
  localparam int DATA_W  = 32;
  localparam int RADDR_W = 8;

  // register offsets (byte addresses)
  localparam logic [RADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [RADDR_W-1:0] OFS_START   = 8'h04;
  localparam logic [RADDR_W-1:0] OFS_STOP    = 8'h08;
  localparam logic [RADDR_W-1:0] OFS_MATCH   = 8'h0C;
  localparam logic [RADDR_W-1:0] OFS_STATUS  = 8'h10;
  localparam logic [RADDR_W-1:0] OFS_PTR     = 8'h14;

  // ctrl fields: written by set_trigger_cmd; a data break in capture modes resets mode to free run
  localparam int CTRL_MODE_LSB   = 0;   // [2:0] mode
  localparam int CTRL_START_KEEP = 4;   // keep previous start address
  localparam int CTRL_STOP_KEEP  = 5;   // keep previous stop address
  localparam int CTRL_START_RUN  = 6;   // start when run command begins
  localparam int CTRL_STOP_NONE  = 7;   // no stop address; trace until the run ends
  localparam int CTRL_SRC_RAM    = 8;   // match source is ram, else probe pins
  // start/stop registers: [14:0] low, [30:16] high
  localparam int RANGE_HI_LSB    = 16;
  // match register: [7:0] compare, [15:8] mask, [27:16] ram address
  localparam int MATCH_MASK_LSB  = 8;
  localparam int MATCH_RAM_LSB   = 16;
  localparam int RAM_ADDR_W      = 12;

  localparam logic [7:0] RAM_MASK_LIMIT = 8'h0F;
  localparam logic [7:0] PRB_MASK_LIMIT = 8'hFF;

  localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;
  localparam logic [PTR_W-1:0]  RST_PTR  = 12'h000;

endpackage

// ==== core/range_hit.sv ====
// address range comparator, inclusive on both ends
// assumes lo <= hi; a single address is lo == hi
module range_hit
  import trace_trigger_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,  // executed address
  input  wire logic [ADDR_W-1:0] lo,    // range low bound
  input  wire logic [ADDR_W-1:0] hi,    // range high bound
  output logic                   hit    // address within range
);

  // inclusive compare
  assign hit = (addr >= lo) && (addr <= hi);

endmodule

// ==== core/trace_trigger_control.sv ====
// trace trigger control: decides which executed instructions go to trace memory
// assumes one exec_valid pulse per executed instruction, with the first byte address
//
// Chosen here: the strobed register port and the address map.
module trace_trigger_control
  import trace_trigger_pkg::*;
(
  input  wire logic               core_clk,     // 40 MHz emulator clock
  input  wire logic               srst,         // synchronous reset, high
  input  wire logic [RADDR_W-1:0] reg_addr,     // register byte address
  input  wire logic [DATA_W-1:0]  reg_wdata,    // register write data
  input  wire logic               reg_wr,       // write strobe
  input  wire logic               reg_rd,       // read strobe
  output logic [DATA_W-1:0]       reg_rdata,    // read data, cycle after strobe
  input  wire logic               run_start,    // run command begins, pulse
  input  wire logic               run_halt,     // emulation halted, pulse
  input  wire logic               break_data,   // break condition is data match
  input  wire logic               exec_valid,   // instruction executed, pulse
  input  wire logic [ADDR_W-1:0]  exec_addr,    // first byte address
  input  wire logic               exec_break,   // this instruction is the break
  input  wire logic               trace_bit,    // enable bit at first byte
  input  wire logic [7:0]         probe_pins,   // probe pin data
  input  wire logic [3:0]         ram_data,     // data ram read value
  output logic [RAM_ADDR_W-1:0]   ram_addr,     // ram location to watch
  output logic                    trace_we,     // write entry, pulse
  output logic [PTR_W-1:0]        trace_ptr     // trace memory pointer
);

  ///////////////////////////////////////////////////////////////////////////
  // trigger registers

  trig_mode_e             mode_ff;
  logic [ADDR_W-1:0]      start_lo_ff, start_hi_ff, stop_lo_ff, stop_hi_ff;
  logic                   start_run_ff, stop_none_ff, src_ram_ff;
  logic [7:0]             cmp_ff, mask_ff;
  logic [RAM_ADDR_W-1:0]  ram_addr_ff;
  logic                   fallback_ff;
  win_state_e             win_ff;
  logic                   we_ff;
  logic [PTR_W-1:0]       ptr_ff;
  logic [DATA_W-1:0]      rdata_ff;

  logic                   wr_ctrl;
  logic [7:0]             mask_eff, src_val;
  logic                   data_hit, start_hit, stop_hit;
  logic                   rec;
  win_state_e             nxt_win;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);

  // mode register, set_trigger_cmd
  // reset to free run
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_ff      <= free_run_mode;
      start_run_ff <= 1'b0;
      stop_none_ff <= 1'b0;
      src_ram_ff   <= 1'b0;
    end else if (wr_ctrl) begin
      mode_ff      <= trig_mode_e'(reg_wdata[CTRL_MODE_LSB +: 3]);
      start_run_ff <= reg_wdata[CTRL_START_RUN];
      stop_none_ff <= reg_wdata[CTRL_STOP_NONE];
      src_ram_ff   <= reg_wdata[CTRL_SRC_RAM];
    end else if (break_data &&
                 (mode_ff == capture_after_match || mode_ff == capture_before_match)) begin
      mode_ff <= free_run_mode;
    end
  end

  // fallback flag, cleared only by a new trigger
  // hold free run
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fallback_ff <= 1'b0;
    end else if (break_data &&
                 (mode_ff == capture_after_match || mode_ff == capture_before_match)) begin
      fallback_ff <= 1'b1;
    end else if (wr_ctrl) begin
      fallback_ff <= 1'b0;
    end
  end

  // window addresses; change only on writes to OFS_START/OFS_STOP, keep bits not decoded
  // keep previous address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_lo_ff <= RST_ADDR;
      start_hi_ff <= RST_ADDR;
      stop_lo_ff  <= RST_ADDR;
      stop_hi_ff  <= RST_ADDR;
    end else if (reg_wr) begin
      if (reg_addr == OFS_START) begin
        start_lo_ff <= reg_wdata[ADDR_W-1:0];
        start_hi_ff <= reg_wdata[RANGE_HI_LSB +: ADDR_W];
      end else if (reg_addr == OFS_STOP) begin
        stop_lo_ff <= reg_wdata[ADDR_W-1:0];
        stop_hi_ff <= reg_wdata[RANGE_HI_LSB +: ADDR_W];
      end
    end
  end

  // match compare, mask and ram location
  // mask width by source
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_ff      <= 8'h00;
      mask_ff     <= PRB_MASK_LIMIT;
      ram_addr_ff <= 12'h000;
    end else if (reg_wr && (reg_addr == OFS_MATCH)) begin
      cmp_ff      <= reg_wdata[7:0];
      mask_ff     <= reg_wdata[MATCH_MASK_LSB +: 8];
      ram_addr_ff <= reg_wdata[MATCH_RAM_LSB +: RAM_ADDR_W];
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // match and address compare

  assign src_val  = src_ram_ff ? {4'h0, ram_data} : probe_pins;
  // ram source uses low 4 mask bits only
  assign mask_eff = src_ram_ff ? (mask_ff & RAM_MASK_LIMIT) : mask_ff;
  assign data_hit = ((src_val ^ cmp_ff) & mask_eff) == 8'h00;

  range_hit u_start (
    .addr (exec_addr),
    .lo   (start_lo_ff),
    .hi   (start_hi_ff),
    .hit  (start_hit)
  );

  range_hit u_stop (
    .addr (exec_addr),
    .lo   (stop_lo_ff),
    .hi   (stop_hi_ff),
    .hit  (stop_hit)
  );

  ///////////////////////////////////////////////////////////////////////////
  // window and match tracking

  // next window state, evaluated per instruction
  // once per instruction
  always_comb begin
    nxt_win = win_ff;
    case (mode_ff)
      start_stop_window: begin
        if (run_start) begin
          nxt_win = start_run_ff ? win_active : win_idle;
        end else if (exec_valid) begin
          if (win_ff == win_idle && start_hit) begin
            nxt_win = win_active;
          end else if (win_ff == win_active && stop_hit && !stop_none_ff) begin
            nxt_win = win_done;
          end
        end
      end
      capture_after_match: begin
        if (run_start) begin
          nxt_win = win_idle;
        end else if (exec_valid && win_ff == win_idle && data_hit) begin
          nxt_win = win_active;
        end
      end
      capture_before_match: begin
        if (run_start) begin
          nxt_win = win_active;
        end else if (exec_valid && win_ff == win_active && data_hit) begin
          nxt_win = win_done;
        end
      end
      default: begin
        nxt_win = win_idle;
      end
    endcase
  end

  // window state register
  always_ff @(posedge core_clk) begin
    if (srst || wr_ctrl) begin
      win_ff <= win_idle;
    end else begin
      win_ff <= nxt_win;
    end
  end

  // record decision for this instruction
  always_comb begin
    rec = 1'b0;
    case (mode_ff)
      free_run_mode:        rec = 1'b1;
      marked_address_mode:  rec = trace_bit;
      no_capture_mode:      rec = 1'b0;
      // stop instruction excluded; break traced when no stop
      start_stop_window:    rec = (nxt_win == win_active) &&
                                  (stop_none_ff || !exec_break || !stop_hit);
      capture_after_match:  rec = (nxt_win == win_active);
      capture_before_match: rec = (win_ff == win_active) && (nxt_win == win_active);
      default:              rec = 1'b0;
    endcase
  end

  ///////////////////////////////////////////////////////////////////////////
  // trace write and pointer

  always_ff @(posedge core_clk) begin
    if (srst) begin
      we_ff  <= 1'b0;
      ptr_ff <= RST_PTR;
    end else begin
      we_ff <= exec_valid && rec && !run_halt;
      if (exec_valid && rec && !run_halt) begin
        ptr_ff <= ptr_ff + 12'h001;
      end
    end
  end

  // ram watch address follows match register
  logic [RAM_ADDR_W-1:0] ram_addr_q_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_addr_q_ff <= 12'h000;
    end else begin
      ram_addr_q_ff <= ram_addr_ff;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // read back, show_trigger_cmd

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_ff <= {23'h000000, src_ram_ff, stop_none_ff, start_run_ff, 2'b00,
                     1'b0, mode_ff};
      end else if (reg_addr == OFS_START) begin
        rdata_ff <= {1'b0, start_hi_ff, 1'b0, start_lo_ff};
      end else if (reg_addr == OFS_STOP) begin
        rdata_ff <= {1'b0, stop_hi_ff, 1'b0, stop_lo_ff};
      end else if (reg_addr == OFS_MATCH) begin
        rdata_ff <= {4'h0, ram_addr_ff, mask_ff, cmp_ff};
      end else if (reg_addr == OFS_STATUS) begin
        rdata_ff <= {28'h0000000, fallback_ff, 1'b0, win_ff};
      end else if (reg_addr == OFS_PTR) begin
        rdata_ff <= {20'h00000, ptr_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign trace_we  = we_ff;
  assign trace_ptr = ptr_ff;
  assign ram_addr  = ram_addr_q_ff;

endmodule

// ==== verification/trace_trigger_control_sva.sv ====
// checker: port relations of the trace trigger block
// assumes one clock and the block's own register map
module trace_trigger_control_sva
  import trace_trigger_pkg::*;
(
  input wire logic                  core_clk,   // clock
  input wire logic                  srst,       // reset
  input wire logic [RADDR_W-1:0]    reg_addr,   // address
  input wire logic [DATA_W-1:0]     reg_wdata,  // write data
  input wire logic                  reg_wr,     // write
  input wire logic                  reg_rd,     // read
  input wire logic [DATA_W-1:0]     reg_rdata,  // read data
  input wire logic                  run_halt,   // halt
  input wire logic                  exec_valid, // executed
  input wire logic                  trace_bit,  // enable bit
  input wire logic [RAM_ADDR_W-1:0] ram_addr,   // ram location
  input wire logic                  trace_we,   // entry write
  input wire logic [PTR_W-1:0]      trace_ptr   // pointer
);
  timeunit 1ns;
  timeprecision 1ps;

  trig_mode_e mode_ff;

  // shadow of the mode last written by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_ff <= free_run_mode;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      mode_ff <= trig_mode_e'(reg_wdata[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  we_cause_a: assert property (
    trace_we |-> $past(exec_valid))
    else $error("entry written without an instruction");
  ptr_step_a: assert property (
    trace_we && !$past(srst) |-> trace_ptr == $past(trace_ptr) + 12'h001)
    else $error("pointer did not step by one");
  ptr_hold_a: assert property (
    !trace_we && !$past(srst) |-> $stable(trace_ptr))
    else $error("pointer moved without an entry");
  no_capture_a: assert property (
    mode_ff == no_capture_mode && $past(mode_ff) == no_capture_mode |-> !trace_we)
    else $error("entry written with capture off");
  free_run_a: assert property (
    mode_ff == free_run_mode && exec_valid && !run_halt |=> trace_we)
    else $error("free run missed an instruction");
  marked_a: assert property (
    mode_ff == marked_address_mode && exec_valid && !run_halt |=> trace_we == $past(trace_bit))
    else $error("marked entry does not follow enable bit");
  ram_addr_a: assert property (
    reg_wr && reg_addr == OFS_MATCH |-> ##2 ram_addr == $past(reg_wdata[27:16], 2))
    else $error("watched ram address not taken");
endmodule

bind trace_trigger_control trace_trigger_control_sva u_trace_trigger_control_sva (
  .core_clk   (core_clk),
  .srst       (srst),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .run_halt   (run_halt),
  .exec_valid (exec_valid),
  .trace_bit  (trace_bit),
  .ram_addr   (ram_addr),
  .trace_we   (trace_we),
  .trace_ptr  (trace_ptr)
);

// ==== verification/exec_source_model.sv ====
// partner: emulated core executing two-byte instructions, with probe and ram data
// assumes go is a one-cycle pulse while idle; each run is count instructions
module exec_source_model
  import trace_trigger_pkg::*;
(
  input  wire logic              core_clk,   // clock
  input  wire logic              srst,       // reset
  input  wire logic              go,         // start a run
  input  wire logic [ADDR_W-1:0] start_pc,   // first address
  input  wire logic [7:0]        count,      // instructions
  input  wire logic              slow,       // every other cycle
  output logic                   run_start,  // run begins
  output logic                   run_halt,   // run ended
  output logic                   exec_valid, // executed
  output logic [ADDR_W-1:0]      exec_addr,  // first byte address
  output logic                   exec_break, // break instruction
  output logic                   trace_bit,  // enable bit
  output logic [7:0]             probe_pins, // probe data
  output logic [3:0]             ram_data,   // ram data
  output logic                   busy        // run in progress
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [ADDR_W-1:0] pc_ff;
  logic [7:0]        left_ff;
  logic              gap_ff;

  ////////////////////////////////////////////////////////////
  // run sequencer; an idle address bus toggles so no stale value survives
  always_ff @(posedge core_clk) begin
    run_start  <= go && !busy;
    run_halt   <= 1'b0;
    exec_valid <= 1'b0;
    exec_break <= 1'b0;
    exec_addr  <= ~exec_addr;
    gap_ff     <= slow && !gap_ff;
    if (srst) begin
      busy      <= 1'b0;
      gap_ff    <= 1'b0;
      exec_addr <= '0;
      {pc_ff, left_ff, trace_bit, probe_pins, ram_data} <= '0;
    end else if (go && !busy) begin
      busy    <= 1'b1;
      pc_ff   <= start_pc;
      left_ff <= count;
    end else if (busy && left_ff == 8'h00) begin
      busy     <= 1'b0;
      run_halt <= 1'b1;
    end else if (busy && !gap_ff) begin
      // one report per instruction, first byte bit
      exec_valid <= 1'b1;
      exec_addr  <= pc_ff;
      exec_break <= left_ff == 8'h01;
      trace_bit  <= pc_ff[1] ^ pc_ff[0];
      probe_pins <= pc_ff[8:1];
      ram_data   <= pc_ff[4:1];
      pc_ff      <= pc_ff + 15'h0002;
      left_ff    <= left_ff - 8'h01;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// testbench: programs the trigger and counts entries over eight-instruction runs
// assumes the core model drives the exec side; bench owns bus and break_data
module testbench
  import trace_trigger_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk, srst, reg_wr, reg_rd, break_data, go, slow, busy;
  logic                  run_start, run_halt, exec_valid, exec_break, trace_bit, trace_we;
  logic [RADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]     reg_wdata, reg_rdata;
  logic [ADDR_W-1:0]     exec_addr, start_pc, prev_a, first_a, last_a;
  logic [7:0]            probe_pins, count;
  logic [3:0]            ram_data;
  logic [RAM_ADDR_W-1:0] ram_addr;
  logic [PTR_W-1:0]      trace_ptr, exp_ptr;
  int                    fails, comparisons, nrec;
  localparam logic [31:0] MC [4] = '{32'h4, 32'h4, 32'h5, 32'h104};
  localparam logic [31:0] MM [4] = '{32'hFF84, 32'hF08F, 32'hFF84, 32'h05A5_FFF3};
  localparam int          MN [4] = '{4, 8, 4, 5};
  localparam logic [14:0] MF [4] = '{15'h108, 15'h100, 15'h100, 15'h106};
  localparam logic [14:0] ML [4] = '{15'h10E, 15'h10E, 15'h106, 15'h10E};

  trace_trigger_control u_trace_trigger_control (.*);
  exec_source_model u_exec_source_model (.*);

  always #12.5 core_clk = ~core_clk;

  // entry monitor: address of each recorded instruction
  always @(posedge core_clk) begin
    if (trace_we) begin
      if (nrec == 0) first_a = prev_a;
      last_a = prev_a;
      nrec++;
    end
    if (exec_valid) prev_a = exec_addr;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata & m, exp);
  endtask
  // eight instructions from 0x100, then entry count, first, last and pointer
  task automatic go_run(input logic s, input int n, input logic [14:0] f, input logic [14:0] l);
    @(posedge core_clk);
    nrec = 0;
    go <= 1'b1;
    slow <= s;
    start_pc <= 15'h0100;
    count <= 8'h08;
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 40 && (busy || i < 2); i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    exp_ptr += n[11:0];
    check(nrec, n);
    if (n > 0) check(first_a, f);
    if (n > 0) check(last_a, l);
    rd(OFS_PTR, 32'hFFF, {20'h0, exp_ptr});
  endtask
  task automatic final_report();
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    {reg_wr, reg_rd, break_data, go, slow} = 5'h00;
    {reg_addr, reg_wdata, start_pc, count} = '0;
    exp_ptr = 12'h000;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(OFS_CTRL, 32'h7, 32'h0);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0);
    go_run(1'b0, 8, 15'h100, 15'h10E);
    go_run(1'b1, 8, 15'h100, 15'h10E);
    wr(OFS_CTRL, 32'h1);
    go_run(1'b0, 4, 15'h102, 15'h10E);
    wr(OFS_CTRL, 32'h2);
    go_run(1'b0, 0, 15'h0, 15'h0);
    // single, then range, then both left as programmed
    for (int i = 0; i < 3; i++) begin
      if (i < 2) wr(OFS_START, i ? 32'h0105_0103 : 32'h0104_0104);
      if (i < 2) wr(OFS_STOP, i ? 32'h010B_0109 : 32'h010A_010A);
      wr(OFS_CTRL, 32'h3);
      go_run(1'b0, 3, 15'h104, 15'h108);
      rd(OFS_STATUS, 32'h3, 32'h2);
    end
    rd(OFS_START, 32'h7FFF_7FFF, 32'h0105_0103);
    rd(OFS_CTRL, 32'h7, 32'h3);
    wr(OFS_CTRL, 32'h43);
    go_run(1'b0, 5, 15'h100, 15'h108);
    wr(OFS_CTRL, 32'hC3);
    go_run(1'b0, 8, 15'h100, 15'h10E);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MATCH, MM[i]);
      wr(OFS_CTRL, MC[i]);
      go_run(1'b0, MN[i], MF[i], ML[i]);
    end
    check(ram_addr, 32'h0000_05A5);
    wr(OFS_MATCH, 32'hFF84);
    wr(OFS_CTRL, 32'h4);
    @(posedge core_clk);
    break_data <= 1'b1;
    @(posedge core_clk);
    break_data <= 1'b0;
    rd(OFS_STATUS, 32'h8, 32'h8);
    rd(OFS_CTRL, 32'h7, 32'h0);
    go_run(1'b0, 8, 15'h100, 15'h10E);
    go_run(1'b1, 8, 15'h100, 15'h10E);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_STATUS, 32'h8, 32'h0);
    final_report();
  end
endmodule
